// [common/epc_pkg.sv]
/*
  epc_pkg: constants and carrier types for the encoder parameter-channel
  command interpreter.
  Assumes a byte-level receiver in front of the interpreter and a byte-level
  transmitter after it, both running on the same clock.
*/
package epc_pkg;

  // ==========================================================================
  // command codes
  localparam logic [7:0] CMD_RD_POS = 8'h42;
  localparam logic [7:0] CMD_SET_POS = 8'h43;
  localparam logic [7:0] CMD_RD_ANA = 8'h44;
  localparam logic [7:0] CMD_RD_CNT = 8'h46;
  localparam logic [7:0] CMD_INC_CNT = 8'h47;
  localparam logic [7:0] CMD_CLR_CNT = 8'h49;
  localparam logic [7:0] CMD_RD_DATA = 8'h4a;
  localparam logic [7:0] CMD_ST_DATA = 8'h4b;
  localparam logic [7:0] CMD_FLD_STAT = 8'h4c;
  localparam logic [7:0] CMD_MK_FLD = 8'h4d;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4e;
  localparam logic [7:0] CMD_RD_STAT = 8'h50;
  localparam logic [7:0] CMD_RD_TYPE = 8'h52;
  localparam logic [7:0] CMD_IDENT = 8'h56;
  localparam logic [7:0] CMD_CFG_SER = 8'h57;

  // ==========================================================================
  // status codes
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_PART_TBL = 8'h03;
  localparam logic [7:0] ST_IBUS = 8'h05;
  localparam logic [7:0] ST_WDOG = 8'h07;
  localparam logic [7:0] ST_PARITY = 8'h09;
  localparam logic [7:0] ST_CHKSUM = 8'h0a;
  localparam logic [7:0] ST_UNK_CMD = 8'h0b;
  localparam logic [7:0] ST_BYTE_CNT = 8'h0c;
  localparam logic [7:0] ST_BAD_ARG = 8'h0d;
  localparam logic [7:0] ST_WR_DENY = 8'h0e;
  localparam logic [7:0] ST_RESIZE = 8'h10;
  localparam logic [7:0] ST_ADDR_RNG = 8'h11;
  localparam logic [7:0] ST_NO_FLD = 8'h12;
  localparam logic [7:0] ST_ANA_MON = 8'h1c;
  localparam logic [7:0] ST_TX_CUR = 8'h1d;
  localparam logic [7:0] ST_OVERSPD = 8'h1f;

  // ==========================================================================
  // defaults and sizes
  localparam logic [7:0] GUARD_DEFAULT = 8'h55;  // factory guard byte
  localparam logic [7:0] DEV_ADDR = 8'h40;       // bus address
  localparam logic [7:0] MODE_DEFAULT = 8'he4;   // serial mode byte
  localparam logic [7:0] TYPE_ID = 8'h5a;        // arbitrary value
  localparam logic [7:0] SERIAL_ID = 8'h3c;      // arbitrary value
  localparam logic [7:0] PROG_VER = 8'h01;       // arbitrary value
  localparam int NFLD = 4;                        // data fields
  localparam int FLD_W = 2;
  localparam int MEM_AW = 7;                      // 128 bytes of user memory
  localparam logic [7:0] MEM_BYTES = 8'h80;
  localparam logic [7:0] FLD_SIZE = 8'h10;       // bytes per created field
  localparam int MAXB = 8;                        // frame buffer length
  localparam int BCNT_W = 4;

  // ==========================================================================
  // carrier types
  typedef struct packed {
    logic [7:0] data;
    logic parity_err;
    logic last;  // final byte of frame (checksum)
  } epc_rx_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } epc_tx_t;

  typedef struct packed {
    logic wdog;
    logic part_tbl;
    logic ibus;
    logic overspd;
    logic tx_cur;
    logic ana_mon;
  } epc_flt_t;

endpackage : epc_pkg

// [rtl/epc_mem.sv]
/*
  epc_mem: user data-field memory, one write port and one registered read.
  Assumes the caller has already checked address range and protection.
*/
`timescale 1ns/1ps
module epc_mem import epc_pkg::*; (
  // clock
  input wire logic clk,
  // write
  input wire logic we,
  input wire logic [MEM_AW-1:0] waddr,
  input wire logic [7:0] wdata,
  // read
  input wire logic [MEM_AW-1:0] raddr,
  output logic [7:0] rdata
);
  // ==========================================================================
  // storage, no reset so it maps onto ram cells
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  // write port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    rdata <= mem[raddr];
  end
endmodule : epc_mem

// [rtl/epc_chk.sv]
/*
  epc_chk: running xor checksum and parity-error tracker for one frame.
  Assumes bytes arrive one per strobe and the frame ends with a last byte.
*/
`timescale 1ns/1ps
module epc_chk import epc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // byte stream
  input wire logic vld,
  input wire epc_rx_t rx,
  // results, valid in the cycle of the last byte
  output logic sum_ok,
  output logic par_bad
);
  // ==========================================================================
  logic [7:0] acc;  // xor of bytes so far
  logic perr;       // sticky parity error within frame

  // checksum accumulator, cleared after each frame
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      acc <= 8'h00;
    end else if (vld) begin
      acc <= rx.last ? 8'h00 : (acc ^ rx.data);
    end
  end

  // parity tracker
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      perr <= 1'b0;
    end else if (vld) begin
      perr <= rx.last ? 1'b0 : (perr | rx.parity_err);
    end
  end

  assign sum_ok = (acc == rx.data);
  assign par_bad = perr | rx.parity_err;
endmodule : epc_chk

// [rtl/epc_top.sv]
/*
  epc_top: command interpreter of the encoder parameter channel.
  Takes received frame bytes (address, command, arguments, checksum), checks
  them and, unless a byte had a parity error, answers with a byte stream whose last byte is the checksum.
  Assumes an external uart strips framing and marks the checksum byte.
*/
`timescale 1ns/1ps

module epc_top import epc_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // received bytes
  input wire logic RX_VALID,
  input wire epc_rx_t RX,
  // answer bytes
  output logic TX_VALID,
  input wire logic TX_READY,
  output epc_tx_t TX,
  // fault sources from the rest of the encoder
  input wire epc_flt_t FAULT,
  // process values
  input wire logic [15:0] POSITION,
  input wire logic [7:0] TEMPERATURE,
  // current serial mode byte
  output logic [7:0] SER_MODE,
  output logic BUSY
);
  // ==========================================================================
  // states
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,  // collecting frame
    S_EXEC = 3'b001,  // decode and check
    S_RDM = 3'b011,   // wait for memory read
    S_SEND = 3'b010,  // shift answer out
    S_DROP = 3'b110   // parity failure, no answer
  } epc_state_t;

  epc_state_t state, next_state;
  logic [7:0] buf_q [0:MAXB-1];   // frame bytes (no checksum)
  logic [BCNT_W-1:0] nb;          // bytes stored
  logic [7:0] ans [0:MAXB-1];     // answer bytes
  logic [BCNT_W-1:0] alen;        // answer length incl. checksum
  logic [BCNT_W-1:0] aidx;        // answer byte index
  logic [7:0] achk;               // running answer checksum
  logic [7:0] status;             // last recorded status
  logic [7:0] guard;              // protection byte
  logic [7:0] mode;               // serial mode
  logic [NFLD-1:0] fld_made;      // created fields
  logic [NFLD-1:0] fld_prot;      // write-protected fields
  logic [7:0] free_mem;           // free user bytes
  logic sum_ok, par_bad;
  logic frame_end;
  logic sum_bad_q, par_bad_q;
  logic mem_we;
  logic [MEM_AW-1:0] mem_addr;
  logic [7:0] mem_rd;

  // ==========================================================================
  // frame checks
  epc_chk u_chk (
    .clk(CLK),
    .rst(RST),
    .vld(RX_VALID),
    .rx(RX),
    .sum_ok(sum_ok),
    .par_bad(par_bad)
  );

  assign frame_end = RX_VALID && RX.last && (state == S_IDLE);

  // ==========================================================================
  // command decode helpers
  logic [7:0] cmd, a1, a2, a3;
  logic [FLD_W-1:0] fsel;
  logic fld_ok, addr_ok;
  logic [BCNT_W-1:0] want;  // expected byte count incl. address and command

  assign cmd = buf_q[1];
  assign a1 = buf_q[2];
  assign a2 = buf_q[3];
  assign a3 = buf_q[4];
  assign fsel = a1[FLD_W-1:0];
  assign fld_ok = (a1 < 8'(NFLD)) && fld_made[fsel];
  assign addr_ok = a2 < FLD_SIZE;
  assign mem_addr = MEM_AW'({fsel, 5'h00} | {2'b00, a2[4:0]});

  // expected frame length per command
  always_comb begin
    case (cmd)
      CMD_RD_DATA: want = BCNT_W'(4);
      CMD_ST_DATA: want = BCNT_W'(5);
      CMD_FLD_STAT: want = BCNT_W'(3);
      CMD_MK_FLD: want = BCNT_W'(5);
      CMD_RD_ANA: want = BCNT_W'(3);
      CMD_CFG_SER: want = BCNT_W'(4);
      default: want = BCNT_W'(2);
    endcase
  end

  // ==========================================================================
  // fault status code; watchdog first, then part table, ibus, overspeed, tx current, analog monitor
  logic [7:0] fault_code;
  always_comb begin
    if (FAULT.wdog) begin
      fault_code = ST_WDOG;
    end else if (FAULT.part_tbl) begin
      fault_code = ST_PART_TBL;
    end else if (FAULT.ibus) begin
      fault_code = ST_IBUS;
    end else if (FAULT.overspd) begin
      fault_code = ST_OVERSPD;
    end else if (FAULT.tx_cur) begin
      fault_code = ST_TX_CUR;
    end else if (FAULT.ana_mon) begin
      fault_code = ST_ANA_MON;
    end else begin
      fault_code = ST_OK;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state <= S_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: begin
        if (frame_end) begin
          next_state = par_bad ? S_DROP : S_EXEC;
        end
      end
      S_EXEC: begin
        next_state = (cmd == CMD_RD_DATA && !sum_bad_q) ? S_RDM : S_SEND;
      end
      S_RDM: next_state = S_SEND;
      S_SEND: begin
        if (TX_READY && aidx == alen - BCNT_W'(1)) begin
          next_state = S_IDLE;
        end
      end
      S_DROP: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // ==========================================================================
  // frame buffer; bytes beyond the buffer are neither kept nor counted, nb stops at MAXB
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      nb <= '0;
    end else if (state == S_IDLE && RX_VALID) begin
      if (RX.last) begin
        nb <= nb;
      end else if (nb != BCNT_W'(MAXB)) begin
        nb <= nb + BCNT_W'(1);
      end
    end else if (state == S_SEND || state == S_DROP) begin
      nb <= '0;
    end
  end

  always_ff @(posedge CLK) begin
    if (state == S_IDLE && RX_VALID && !RX.last && nb < BCNT_W'(MAXB)) begin
      buf_q[nb[2:0]] <= RX.data;
    end
  end

  // latch frame check results at the checksum byte
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sum_bad_q <= 1'b0;
      par_bad_q <= 1'b0;
    end else if (frame_end) begin
      sum_bad_q <= !sum_ok;
      par_bad_q <= par_bad;
    end
  end

  // ==========================================================================
  // user memory
  assign mem_we = (state == S_EXEC) && (cmd == CMD_ST_DATA) && !sum_bad_q
                  && (nb == want) && fld_ok && addr_ok && !fld_prot[fsel];
  epc_mem u_mem (
    .clk(CLK),
    .we(mem_we),
    .waddr(mem_addr),
    .wdata(a3),
    .raddr(mem_addr),
    .rdata(mem_rd)
  );

  // ==========================================================================
  // execution: status, configuration and field table
  logic [7:0] err;
  always_comb begin
    err = ST_OK;
    if (sum_bad_q) begin
      err = ST_CHKSUM;
    end else begin
      case (cmd)
        CMD_RD_POS, CMD_RD_CNT, CMD_RD_STAT, CMD_RD_TYPE, CMD_IDENT,
        CMD_FREE_MEM: begin
          if (nb != want) err = ST_BYTE_CNT;
        end
        CMD_RD_ANA: begin
          if (nb != want) err = ST_BYTE_CNT;
          else if (a1 != 8'h48) err = ST_BAD_ARG;
        end
        CMD_RD_DATA, CMD_ST_DATA: begin
          if (nb != want) err = ST_BYTE_CNT;
          else if (!fld_ok) err = ST_NO_FLD;
          else if (!addr_ok) err = ST_ADDR_RNG;
          else if (cmd == CMD_ST_DATA && fld_prot[fsel])
            err = ST_WR_DENY;
        end
        CMD_FLD_STAT: begin
          if (nb != want) err = ST_BYTE_CNT;
          else if (!fld_ok) err = ST_NO_FLD;
        end
        CMD_MK_FLD: begin
          if (nb != want) err = ST_BYTE_CNT;
          else if (a1 >= 8'(NFLD)) err = ST_BAD_ARG;
          else if (fld_made[fsel]) err = ST_RESIZE;
          else if (a2 != FLD_SIZE) err = ST_BAD_ARG;
        end
        CMD_CFG_SER: begin
          if (nb != want) err = ST_BYTE_CNT;
          else if (a1 != guard) err = ST_BAD_ARG;
        end
        default: err = ST_UNK_CMD;
      endcase
    end
  end

  // status register: parity errors recorded without an answer
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      status <= ST_OK;
    end else if (state == S_DROP) begin
      status <= ST_PARITY;
    end else if (state == S_EXEC) begin
      status <= (err != ST_OK) ? err : fault_code;
    end
  end

  // guard byte and mode; guard only changes by reset here
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      guard <= GUARD_DEFAULT;
      mode <= MODE_DEFAULT;
    end else if (state == S_EXEC && cmd == CMD_CFG_SER && err == ST_OK) begin
      mode <= a2;
    end
  end

  // field table: created fields are fixed size and write-protected when bit 0 of a3 is set
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fld_made <= '0;
      fld_prot <= '0;
      free_mem <= MEM_BYTES;
    end else if (state == S_EXEC && cmd == CMD_MK_FLD && err == ST_OK) begin
      fld_made[fsel] <= 1'b1;
      fld_prot[fsel] <= a3[0];
      free_mem <= free_mem - FLD_SIZE;
    end
  end

  // ==========================================================================
  // answer assembly: address, command, payload (or status on error)
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      alen <= '0;
      for (int i = 0; i < MAXB; i++) ans[i] <= 8'h00;
    end else if (state == S_EXEC) begin
      ans[0] <= DEV_ADDR;
      ans[1] <= cmd;
      alen <= BCNT_W'(4);
      if (err != ST_OK) begin
        ans[1] <= cmd | 8'h80;  // error answer marks the command byte
        ans[2] <= err;
      end else begin
        case (cmd)
          CMD_RD_POS: begin
            ans[2] <= FAULT.overspd ? ST_OVERSPD : POSITION[15:8];
            ans[3] <= POSITION[7:0];
            alen <= BCNT_W'(5);
          end
          CMD_RD_ANA: ans[2] <= TEMPERATURE;
          CMD_RD_STAT: ans[2] <= status;
          CMD_RD_TYPE: ans[2] <= TYPE_ID;
          CMD_IDENT: begin
            ans[2] <= SERIAL_ID;
            ans[3] <= PROG_VER;
            alen <= BCNT_W'(5);
          end
          CMD_FREE_MEM: ans[2] <= free_mem;
          CMD_FLD_STAT: ans[2] <= {7'h00, fld_prot[fsel]};
          default: ans[2] <= fault_code;
        endcase
      end
    end else if (state == S_RDM && ans[1] == CMD_RD_DATA) begin
      // an error answer keeps its status code
      ans[2] <= mem_rd;
    end
  end

  // answer shifter with running checksum appended last
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aidx <= '0;
      achk <= 8'h00;
    end else if (state != S_SEND) begin
      aidx <= '0;
      achk <= 8'h00;
    end else if (TX_READY) begin
      aidx <= aidx + BCNT_W'(1);
      achk <= achk ^ ans[aidx[2:0]];
    end
  end

  // ==========================================================================
  // outputs
  assign TX_VALID = (state == S_SEND);
  logic tx_last;  // checksum byte is up
  assign tx_last = (aidx == alen - BCNT_W'(1));
  // one driver for the whole struct, members assigned together
  assign TX = '{data: (tx_last ? achk : ans[aidx[2:0]]), last: tx_last};
  assign SER_MODE = mode;
  assign BUSY = (state != S_IDLE);
endmodule : epc_top

// [testbench/epc_host_sink.sv]
/*
  epc_host_sink: answer side of the bus master, takes the interpreter's
  answer bytes with a ready that can be paced down to one cycle in three.
  Assumes the bench clears it at the start of each request frame.
*/
`timescale 1ns/1ps
module epc_host_sink import epc_pkg::*; (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // answer stream
  input wire logic tx_valid,
  input wire epc_tx_t tx,
  output logic tx_ready,
  // bench control
  input wire logic slow,
  input wire logic clr,
  // captured answer
  output logic [7:0] ans [0:7],
  output logic [3:0] n,
  output logic done
);
  logic [1:0] div;  // pacing divider

  // ==========================================================================
  // ready pacing, changed just after the edge so a stall is seen whole
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      tx_ready <= !slow || (div == 2'h2);
    end
  end

  // ==========================================================================
  // capture; bytes after the last one are not taken, so a runaway shows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      n <= 4'h0;
      done <= 1'b0;
    end else if (clr) begin
      n <= 4'h0;
      done <= 1'b0;
    end else if (tx_valid && tx_ready && !done) begin
      ans[n[2:0]] <= tx.data;
      n <= n + 4'h1;
      done <= tx.last;
    end
  end
endmodule : epc_host_sink

// [testbench/epc_top_props.sv]
/*
  epc_top_props: timing checks on the interpreter's ports.
  Assumes it is bound to epc_top and sees only its ports.
*/
`timescale 1ns/1ps
module epc_top_props import epc_pkg::*; (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // request and answer
  input wire logic RX_VALID,
  input wire epc_rx_t RX,
  input wire logic TX_VALID,
  input wire logic TX_READY,
  input wire epc_tx_t TX,
  // side signals
  input wire epc_flt_t FAULT,
  input wire logic [15:0] POSITION,
  input wire logic [7:0] TEMPERATURE,
  input wire logic [7:0] SER_MODE,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic par_seen;  // parity fault earlier in this frame
  logic [7:0] acc;  // xor of answer bytes so far
  wire fin = RX_VALID && !BUSY && RX.last;  // checksum byte taken
  wire bad = fin && (par_seen || RX.parity_err);

  // ==========================================================================
  // helpers
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      par_seen <= 1'b0;
    end else if (RX_VALID && !BUSY) begin
      par_seen <= RX.last ? 1'b0 : (par_seen | RX.parity_err);
    end
  end
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      acc <= 8'h00;
    end else if (TX_VALID && TX_READY) begin
      acc <= TX.last ? 8'h00 : (acc ^ TX.data);
    end
  end

  // ==========================================================================
  // properties
  property p_answer; fin && !bad |-> ##[2:3] TX_VALID; endproperty
  property p_silent; bad |=> !TX_VALID [*6]; endproperty
  property p_stand; TX_VALID && !TX_READY |=> TX_VALID && $stable(TX);
  endproperty
  property p_first; $rose(TX_VALID) |-> TX.data == DEV_ADDR && !TX.last;
  endproperty
  property p_sum; TX_VALID && TX_READY && TX.last |-> TX.data == acc;
  endproperty
  property p_idle; TX_VALID && TX_READY && TX.last |=> !TX_VALID && !BUSY;
  endproperty
  property p_busy; TX_VALID |-> BUSY; endproperty
  property p_take; fin && !bad |=> BUSY; endproperty
  property p_mode; $changed(SER_MODE) |-> $past(BUSY); endproperty
  a_answer: assert property (p_answer)
    else $error("answer did not start in time");
  a_silent: assert property (p_silent)
    else $error("answer sent after parity fault");
  a_stand: assert property (p_stand)
    else $error("answer byte changed while stalled");
  a_first: assert property (p_first)
    else $error("answer does not open with the address");
  a_sum: assert property (p_sum)
    else $error("answer checksum wrong");
  a_idle: assert property (p_idle)
    else $error("not idle after the answer");
  a_busy: assert property (p_busy)
    else $error("answer while idle");
  a_take: assert property (p_take)
    else $error("frame not taken");
  a_mode: assert property (p_mode)
    else $error("serial mode changed outside a command");
  c_frame: cover property (fin && !bad);
  c_stall: cover property (TX_VALID && !TX_READY);
  c_par: cover property (bad);
endmodule : epc_top_props

bind epc_top epc_top_props i_props (.CLK(CLK), .RST(RST),
  .RX_VALID(RX_VALID), .RX(RX), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
  .TX(TX), .FAULT(FAULT), .POSITION(POSITION), .TEMPERATURE(TEMPERATURE),
  .SER_MODE(SER_MODE), .BUSY(BUSY));

// [testbench/tb.sv]
/*
  tb: self-checking bench for epc_top, frames sent byte by byte.
  Assumes epc_host_sink takes the answers and the checker is bound.
*/
`timescale 1ns/1ps
module tb import epc_pkg::*; ;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rx_valid = 1'b0;
  epc_rx_t rx = '0;
  epc_flt_t fault = '0;
  logic [15:0] position = 16'h1234;
  logic [7:0] temperature = 8'h2a;
  logic tx_valid, tx_ready, busy, done;
  epc_tx_t tx;
  logic [7:0] ser_mode;
  logic slow = 1'b0;  // pace the sink down
  logic clr = 1'b0;
  logic [7:0] ans [0:7];
  logic [3:0] n;
  int error_cnt = 0;
  int comparisons = 0;

  epc_top i_dut (.CLK(clk), .RST(rst), .RX_VALID(rx_valid), .RX(rx),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX(tx), .FAULT(fault),
    .POSITION(position), .TEMPERATURE(temperature), .SER_MODE(ser_mode),
    .BUSY(busy));
  epc_host_sink i_host (.clk(clk), .rst(rst), .tx_valid(tx_valid), .tx(tx),
    .tx_ready(tx_ready), .slow(slow), .clr(clr), .ans(ans), .n(n),
    .done(done));

  initial begin
    forever #2 clk = ~clk;
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string what);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  task automatic stuck(input string what);
    error_cnt++;
    $display("mismatch %s expected end seen timeout", what);
    final_report();
  endtask : stuck
  // one frame: address, command, na arguments, checksum (bad inverts it)
  task automatic send(input int na, input logic [7:0] cmd, a0, a1, a2,
                      input logic bad, input logic par);
    logic [7:0] b [0:4];
    logic [7:0] s;
    int k;
    b = '{DEV_ADDR, cmd, a0, a1, a2};
    s = 8'h00;
    for (k = 0; k < 200 && busy !== 1'b0; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 200) stuck("idle");
    for (k = 0; k < na + 3; k++) begin
      @(posedge clk);
      #1;
      clr = (k == 0);
      rx_valid = 1'b1;
      if (k < na + 2) begin
        rx = '{b[k], 1'b0, 1'b0};
        s = s ^ b[k];
      end else begin
        rx = '{bad ? ~s : s, par, 1'b1};
      end
    end
    @(posedge clk);
    #1;
    rx_valid = 1'b0;
    clr = 1'b0;
  endtask : send
  task automatic answer;
    logic [7:0] x;
    int k;
    for (k = 0; k < 300 && done !== 1'b1; k++) begin
      @(posedge clk);
      #1;
    end
    if (k == 300) stuck("answer");
    x = 8'h00;
    for (k = 0; k < n; k++) x = x ^ ans[k];
    chk(x, 8'h00, "answer checksum");
    chk(ans[0], DEV_ADDR, "answer address");
  endtask : answer
  task automatic req(input int na, input logic [7:0] cmd, a0, a1, a2);
    send(na, cmd, a0, a1, a2, 1'b0, 1'b0);
    answer();
  endtask : req
  task automatic err(input logic [7:0] cmd, input logic [7:0] code);
    chk(ans[1], cmd | 8'h80, "error command");
    chk(ans[2], code, "error status");
    chk({4'h0, n}, 8'h04, "error length");
  endtask : err

  // ==========================================================================
  // scenarios
  task automatic t_basic;
    req(0, CMD_RD_STAT, 8'h00, 8'h00, 8'h00);
    chk(ans[2], ST_OK, "clear status");
    req(0, CMD_IDENT, 8'h00, 8'h00, 8'h00);
    chk(ans[2], SERIAL_ID, "serial");
    chk(ans[3], PROG_VER, "version");
    req(1, CMD_RD_ANA, 8'h48, 8'h00, 8'h00);
    chk(ans[2], temperature, "temperature");
    req(1, CMD_RD_ANA, 8'h47, 8'h00, 8'h00);
    err(CMD_RD_ANA, ST_BAD_ARG);
    $display("basic test done");
  endtask : t_basic
  task automatic t_guard;
    chk(ser_mode, MODE_DEFAULT, "mode reset");
    req(2, CMD_CFG_SER, GUARD_DEFAULT, 8'hc3, 8'h00);
    chk(ans[1], CMD_CFG_SER, "guarded accept");
    chk(ser_mode, 8'hc3, "mode set");
    req(2, CMD_CFG_SER, 8'h54, 8'h11, 8'h00);
    chk(ans[1], CMD_CFG_SER | 8'h80, "guard refused");
    chk(ser_mode, 8'hc3, "mode kept");
    // a reset in mid-run brings the serial mode back to its default
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(ser_mode, MODE_DEFAULT, "mode after reset");
    $display("guard test done");
  endtask : t_guard
  task automatic t_proto;
    send(0, CMD_RD_STAT, 8'h00, 8'h00, 8'h00, 1'b1, 1'b0);
    answer();
    err(CMD_RD_STAT, ST_CHKSUM);
    req(1, CMD_RD_STAT, 8'h00, 8'h00, 8'h00);
    err(CMD_RD_STAT, ST_BYTE_CNT);
    req(0, 8'h45, 8'h00, 8'h00, 8'h00);
    err(8'h45, ST_UNK_CMD);
    send(0, CMD_RD_STAT, 8'h00, 8'h00, 8'h00, 1'b0, 1'b1);
    repeat (20) @(posedge clk);
    chk({7'h0, done}, 8'h00, "parity silent");
    req(0, CMD_RD_STAT, 8'h00, 8'h00, 8'h00);
    chk(ans[2], ST_PARITY, "parity status");
    $display("protocol test done");
  endtask : t_proto
  task automatic t_fields;
    slow = 1'b1;
    req(2, CMD_RD_DATA, 8'h00, 8'h00, 8'h00);
    err(CMD_RD_DATA, ST_NO_FLD);
    req(3, CMD_MK_FLD, 8'h00, 8'h11, 8'h00);
    err(CMD_MK_FLD, ST_BAD_ARG);
    req(3, CMD_MK_FLD, 8'h00, FLD_SIZE, 8'h00);
    chk(ans[1], CMD_MK_FLD, "create");
    req(3, CMD_MK_FLD, 8'h00, 8'h11, 8'h00);
    err(CMD_MK_FLD, ST_RESIZE);
    req(0, CMD_FREE_MEM, 8'h00, 8'h00, 8'h00);
    chk(ans[2], MEM_BYTES - FLD_SIZE, "free memory");
    req(3, CMD_ST_DATA, 8'h00, 8'h03, 8'ha5);
    chk(ans[1], CMD_ST_DATA, "store");
    req(2, CMD_RD_DATA, 8'h00, 8'h03, 8'h00);
    chk(ans[2], 8'ha5, "read back");
    req(2, CMD_RD_DATA, 8'h00, 8'hff, 8'h00);
    err(CMD_RD_DATA, ST_ADDR_RNG);
    req(1, CMD_FLD_STAT, 8'h00, 8'h00, 8'h00);
    chk(ans[1], CMD_FLD_STAT, "field status");
    req(3, CMD_MK_FLD, 8'h01, FLD_SIZE, 8'h01);
    req(3, CMD_ST_DATA, 8'h01, 8'h00, 8'h5a);
    err(CMD_ST_DATA, ST_WR_DENY);
    slow = 1'b0;
    $display("field test done");
  endtask : t_fields
  task automatic t_faults;
    logic [7:0] code [0:5];
    int i;
    code = '{ST_WDOG, ST_PART_TBL, ST_IBUS, ST_OVERSPD, ST_TX_CUR,
             ST_ANA_MON};
    for (i = 0; i < 6; i++) begin
      fault = epc_flt_t'(6'h20 >> i);
      // status is recorded by one command and read back by the next
      req(0, CMD_RD_TYPE, 8'h00, 8'h00, 8'h00);
      chk(ans[2], TYPE_ID, "type");
      req(0, CMD_RD_STAT, 8'h00, 8'h00, 8'h00);
      chk(ans[2], code[i], "fault status");
    end
    fault = epc_flt_t'(6'h04);
    req(0, CMD_RD_POS, 8'h00, 8'h00, 8'h00);
    chk(ans[2], ST_OVERSPD, "overspeed position");
    fault = '0;
    req(0, CMD_RD_POS, 8'h00, 8'h00, 8'h00);
    chk(ans[2], position[15:8], "position high");
    chk(ans[3], position[7:0], "position low");
    $display("fault test done");
  endtask : t_faults

  // ==========================================================================
  // main sequence; the basic test runs first so its status read sees the reset value
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_basic();
    t_guard();
    t_proto();
    t_fields();
    t_faults();
    final_report();
  end
endmodule : tb
